/* File: hdl/nvb_ctrl.sv */
// Purpose: cpu-side register file and sequencer for byte access to the nv array
// Assumes: cpu register port synchronous to sys_clk; reads answered one cycle later
// Notes: the control register is reached only through the indirect port with bank 1
`timescale 1ns/1ps
`default_nettype none
`include "nvb_defines.svh"

module nvb_ctrl (
    input wire logic sys_clk, // system clock, 125 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] regAddr, // direct data memory address
    input wire logic regWr, // register write strobe
    input wire logic regRd, // register read strobe
    input wire logic [7:0] regWdata, // write data
    input wire logic stackFull, // call stack has no room
    output logic [7:0] regRdata, // read data, one cycle after regRd
    output logic irqCall, // one-cycle call to the nv vector
    output logic nvBusy // a read or write cycle is in progress
);
    import nvb_pkg::*;

    nvb_state_e state_q, state_d;
    logic storeArm_q, storeArm_d, storeGo_q, storeGo_d, fetchArm_q, fetchArm_d, fetchGo_q, fetchGo_d;
    logic bankSel_q, bankSel_d, gie_q, gie_d, nvIe_q, nvIe_d, nvFlag_q, nvFlag_d;
    logic irqCall_q, irqCall_d, nvBusy_q, nvBusy_d;
    logic [7:0] ptr_q, ptr_d, nvData_q, nvData_d, rdata_q, rdata_d;
    logic [4:0] nvAddr_q, nvAddr_d;
    logic wrStart, rdStart, arrWrDone, arrRdDone;
    logic [7:0] arrRdData;
    nvb_sel_e sel;

    ////////////////////////////////////////////////////////////////////////////
    // address decode, shared by the read and write paths

    function automatic nvb_sel_e nvbDecode(input logic bank, input logic [7:0] addr);
        nvb_sel_e s;
        s = NVB_SEL_NONE;
        if (bank == `NVB_CTRL_BANK)
        begin
            if (addr == `NVB_OFF_CTRL)
            begin
                s = NVB_SEL_CTRL;
            end
        end
        else
        begin
            case (addr)
                `NVB_OFF_ADDR: s = NVB_SEL_ADDR;
                `NVB_OFF_DATA: s = NVB_SEL_DATA;
                `NVB_OFF_BANK: s = NVB_SEL_BANK;
                `NVB_OFF_IND_PTR: s = NVB_SEL_PTR;
                `NVB_OFF_IRQ: s = NVB_SEL_IRQ;
                default: s = NVB_SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // direct access is always bank 0; the indirect port follows pointer and bank
    always_comb
    begin
        if (regAddr == `NVB_OFF_IND_PORT)
        begin
            sel = nvbDecode(bankSel_q, ptr_q);
        end
        else
        begin
            sel = nvbDecode(1'b0, regAddr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and sequencer

    always_comb
    begin
        state_d = state_q;
        storeArm_d = storeArm_q;
        storeGo_d = storeGo_q;
        fetchArm_d = fetchArm_q;
        fetchGo_d = fetchGo_q;
        bankSel_d = bankSel_q;
        ptr_d = ptr_q;
        nvAddr_d = nvAddr_q;
        nvData_d = nvData_q;
        gie_d = gie_q;
        nvIe_d = nvIe_q;
        nvFlag_d = nvFlag_q;
        wrStart = 1'b0;
        rdStart = 1'b0;
        if (regWr)
        begin
            case (sel)
                NVB_SEL_ADDR: nvAddr_d = regWdata[4:0];
                NVB_SEL_DATA: nvData_d = regWdata;
                NVB_SEL_BANK: bankSel_d = regWdata[0];
                NVB_SEL_PTR: ptr_d = regWdata;
                NVB_SEL_IRQ:
                begin
                    gie_d = regWdata[`NVB_BIT_GIE];
                    nvIe_d = regWdata[`NVB_BIT_NV_IE];
                    nvFlag_d = regWdata[`NVB_BIT_NV_FLAG];
                end
                NVB_SEL_CTRL:
                begin
                    storeArm_d = regWdata[`NVB_BIT_STORE_ARM];
                    fetchArm_d = regWdata[`NVB_BIT_FETCH_ARM];
                    // go bits only rise, and only if armed before this write
                    if (state_q == NVB_ST_IDLE && regWdata[`NVB_BIT_STORE_GO] && storeArm_q)
                    begin
                        storeGo_d = 1'b1;
                        wrStart = 1'b1;
                        state_d = NVB_ST_WRITE;
                    end
                    else if (state_q == NVB_ST_IDLE && regWdata[`NVB_BIT_FETCH_GO] && fetchArm_q)
                    begin
                        fetchGo_d = 1'b1;
                        rdStart = 1'b1;
                        state_d = NVB_ST_READ;
                    end
                end
                default:
                begin
                end
            endcase
        end
        case (state_q)
            NVB_ST_READ:
            begin
                if (arrRdDone)
                begin
                    fetchGo_d = 1'b0;
                    nvData_d = arrRdData;
                    state_d = NVB_ST_IDLE;
                end
            end
            NVB_ST_WRITE:
            begin
                if (arrWrDone)
                begin
                    storeGo_d = 1'b0;
                    state_d = NVB_ST_IDLE;
                end
            end
            default:
            begin
            end
        endcase
        // servicing the call drops the flag and the global enable; hardware beats software
        if (irqCall_q)
        begin
            nvFlag_d = 1'b0;
            gie_d = 1'b0;
        end
        // a write end in the same cycle as a clear still leaves the flag set
        if (state_q == NVB_ST_WRITE && arrWrDone)
        begin
            nvFlag_d = 1'b1;
        end
    end

    always_comb
    begin
        irqCall_d = nvFlag_q && nvIe_q && gie_q && !stackFull && !irqCall_q;
        nvBusy_d = state_d != NVB_ST_IDLE;
        rdata_d = rdata_q;
        if (regRd)
        begin
            case (sel)
                NVB_SEL_ADDR: rdata_d = {3'h0, nvAddr_q};
                NVB_SEL_DATA: rdata_d = nvData_q;
                NVB_SEL_BANK: rdata_d = {7'h00, bankSel_q};
                NVB_SEL_PTR: rdata_d = ptr_q;
                NVB_SEL_IRQ: rdata_d = {5'h00, nvFlag_q, nvIe_q, gie_q};
                NVB_SEL_CTRL: rdata_d = {4'h0, storeArm_q, storeGo_q, fetchArm_q, fetchGo_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= NVB_ST_IDLE;
            storeArm_q <= 1'b0;
            storeGo_q <= 1'b0;
            fetchArm_q <= 1'b0;
            fetchGo_q <= 1'b0;
            bankSel_q <= 1'b0;
            ptr_q <= `NVB_RST_BYTE;
            nvAddr_q <= `NVB_RST_ADDR;
            nvData_q <= `NVB_RST_BYTE;
            gie_q <= 1'b0;
            nvIe_q <= 1'b0;
            nvFlag_q <= 1'b0;
            irqCall_q <= 1'b0;
            nvBusy_q <= 1'b0;
            rdata_q <= `NVB_RST_BYTE;
        end
        else
        begin
            state_q <= state_d;
            storeArm_q <= storeArm_d;
            storeGo_q <= storeGo_d;
            fetchArm_q <= fetchArm_d;
            fetchGo_q <= fetchGo_d;
            bankSel_q <= bankSel_d;
            ptr_q <= ptr_d;
            nvAddr_q <= nvAddr_d;
            nvData_q <= nvData_d;
            gie_q <= gie_d;
            nvIe_q <= nvIe_d;
            nvFlag_q <= nvFlag_d;
            irqCall_q <= irqCall_d;
            nvBusy_q <= nvBusy_d;
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;
    assign irqCall = irqCall_q;
    assign nvBusy = nvBusy_q;

    ////////////////////////////////////////////////////////////////////////////
    // array with its own write timer

    nvb_array uArray (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wrStart(wrStart),
        .rdStart(rdStart),
        .addr(nvAddr_q),
        .wdata(nvData_q),
        .rdData(arrRdData),
        .wrDone(arrWrDone),
        .rdDone(arrRdDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_ctrl_write(int bit_no);
        regWr && sel == NVB_SEL_CTRL && regWdata[bit_no] && state_q == NVB_ST_IDLE;
    endsequence

    property p_store_needs_arm;
        @(posedge sys_clk) disable iff (!rst_n)
        s_ctrl_write(`NVB_BIT_STORE_GO) and !storeArm_q |=> !storeGo_q;
    endproperty
    a_store_needs_arm: assert property (p_store_needs_arm) else $error("write started while unarmed");

    property p_store_go_clears;
        @(posedge sys_clk) disable iff (!rst_n)
        storeGo_q && arrWrDone |=> !storeGo_q && state_q == NVB_ST_IDLE;
    endproperty
    a_store_go_clears: assert property (p_store_go_clears) else $error("store_go not cleared at write end");

    property p_fetch_needs_arm;
        @(posedge sys_clk) disable iff (!rst_n)
        s_ctrl_write(`NVB_BIT_FETCH_GO) and !fetchArm_q and !regWdata[`NVB_BIT_STORE_GO] |=> !fetchGo_q;
    endproperty
    a_fetch_needs_arm: assert property (p_fetch_needs_arm) else $error("read started while unarmed");

    property p_fetch_finishes;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(fetchGo_q) |-> ##[1:4] !fetchGo_q;
    endproperty
    a_fetch_finishes: assert property (p_fetch_finishes) else $error("read did not finish in time");

    property p_read_data_lands;
        @(posedge sys_clk) disable iff (!rst_n)
        fetchGo_q && arrRdDone |=> nvData_q == $past(arrRdData) && !fetchGo_q;
    endproperty
    a_read_data_lands: assert property (p_read_data_lands) else $error("read byte not placed in data reg");

    property p_write_takes_time;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(storeGo_q) |-> storeGo_q [*8];
    endproperty
    a_write_takes_time: assert property (p_write_takes_time) else $error("write ended too soon");

    property p_flag_on_write_end;
        @(posedge sys_clk) disable iff (!rst_n)
        state_q == NVB_ST_WRITE && arrWrDone |=> nvFlag_q ##1 (irqCall_q || !gie_q || !nvIe_q || $past(stackFull));
    endproperty
    a_flag_on_write_end: assert property (p_flag_on_write_end) else $error("write end did not raise flag or call");

    property p_service_clears;
        @(posedge sys_clk) disable iff (!rst_n)
        irqCall_q |=> !gie_q && !irqCall_q;
    endproperty
    a_service_clears: assert property (p_service_clears) else $error("servicing left enable set");

    property p_ctrl_not_direct;
        @(posedge sys_clk) disable iff (!rst_n)
        regWr && regAddr == `NVB_OFF_CTRL |=> storeArm_q == $past(storeArm_q) && fetchArm_q == $past(fetchArm_q);
    endproperty
    a_ctrl_not_direct: assert property (p_ctrl_not_direct) else $error("control reached by direct address");

endmodule
`default_nettype wire

/* File: hdl/nvb_defines.svh */
// Purpose: offsets, field positions, reset values and timing counts of the nv byte access block
// Assumes: 125 MHz sys_clk, byte-wide cpu register port
// Notes: direct offsets are bank 0; the control register lives only at 40h of bank 1
//
// What this block does
// - a 32 byte non-volatile store accessed one byte at a time
// - address and data in bank 0; control at 40h bank 1, indirect only
// - store_arm at bit 3 enables writes; while zero no new array write starts, a running one still finishes
// - store_go at bit 2 starts a write only if armed; hardware clears it at end
// - fetch_arm at bit 1 enables reads; while zero no new array read starts, a running one still finishes
// - fetch_go at bit 0 starts a read only if armed; hardware clears it at end
// - a finished read puts the byte in nv_data; it stays until next access
// - each write is timed by an internal timer, variable in clock cycles
// - power-on clears store_arm and resets bank select to zero
// - write end sets nv_irq_flag; enabled and stack not full calls the vector
// - servicing the call clears nv_irq_flag and global_irq_enable
`ifndef NVB_DEFINES_SVH
`define NVB_DEFINES_SVH

// register offsets as seen by the cpu
`define NVB_OFF_IND_PORT 8'h02
`define NVB_OFF_IND_PTR 8'h03
`define NVB_OFF_BANK 8'h04
`define NVB_OFF_IRQ 8'h0e
`define NVB_OFF_ADDR 8'h1c
`define NVB_OFF_DATA 8'h1d
`define NVB_OFF_CTRL 8'h40
`define NVB_CTRL_BANK 1'b1

// control fields
`define NVB_BIT_FETCH_GO 0
`define NVB_BIT_FETCH_ARM 1
`define NVB_BIT_STORE_GO 2
`define NVB_BIT_STORE_ARM 3

// interrupt register fields
`define NVB_BIT_GIE 0
`define NVB_BIT_NV_IE 1
`define NVB_BIT_NV_FLAG 2

// reset values
`define NVB_RST_BYTE 8'h00
`define NVB_RST_ADDR 5'h00
`define NVB_RST_LFSR 4'h1

// timing
`define NVB_CLK_PERIOD_NS 8
`define NVB_WR_TIME_NS 2000
`define NVB_WR_CYCLES ((`NVB_WR_TIME_NS + `NVB_CLK_PERIOD_NS - 1) / `NVB_CLK_PERIOD_NS)
`define NVB_RD_CYCLES 2

`endif

/* File: hdl/nvb_pkg.sv */
// Purpose: shared types of the nv byte access block
// Assumes: nothing beyond SystemVerilog packages
// Notes: constants live in nvb_defines.svh
package nvb_pkg;

    typedef enum logic [1:0] {
        NVB_ST_IDLE = 2'b00,
        NVB_ST_READ = 2'b01,
        NVB_ST_WRITE = 2'b10
    } nvb_state_e;

    typedef enum logic [2:0] {
        NVB_SEL_NONE = 3'b000,
        NVB_SEL_ADDR = 3'b001,
        NVB_SEL_DATA = 3'b010,
        NVB_SEL_CTRL = 3'b011,
        NVB_SEL_BANK = 3'b100,
        NVB_SEL_PTR = 3'b101,
        NVB_SEL_IRQ = 3'b110
    } nvb_sel_e;

endpackage

/* File: hdl/nvb_array.sv */
// Purpose: 32x8 non-volatile array model with its own write timer
// Assumes: one start at a time from the controller
// Notes: write length varies with a free-running lfsr
`timescale 1ns/1ps
`default_nettype none
`include "nvb_defines.svh"

module nvb_array (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic wrStart, // start a write cycle
    input wire logic rdStart, // start a read cycle
    input wire logic [4:0] addr, // byte address
    input wire logic [7:0] wdata, // byte to store
    output logic [7:0] rdData, // byte fetched
    output logic wrDone, // write finished pulse
    output logic rdDone // read finished pulse
);
    import nvb_pkg::*;

    logic [7:0] mem [0:31];
    logic wrBusy_q, wrBusy_d, rdBusy_q, rdBusy_d, wrDone_q, wrDone_d, rdDone_q, rdDone_d;
    logic [8:0] cnt_q, cnt_d;
    logic [3:0] lfsr_q, lfsr_d;
    logic [4:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d, rdData_q, rdData_d;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        // timer runs apart from any cpu timing, so its length wanders
        lfsr_d = {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
        wrBusy_d = wrBusy_q;
        rdBusy_d = rdBusy_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdData_d = rdData_q;
        wrDone_d = 1'b0;
        rdDone_d = 1'b0;
        if (wrStart && !wrBusy_q && !rdBusy_q)
        begin
            wrBusy_d = 1'b1;
            cnt_d = 9'(`NVB_WR_CYCLES) + {5'h00, lfsr_q};
            addr_d = addr;
            wdata_d = wdata;
        end
        else if (rdStart && !wrBusy_q && !rdBusy_q)
        begin
            rdBusy_d = 1'b1;
            cnt_d = 9'(`NVB_RD_CYCLES);
            addr_d = addr;
        end
        else if (wrBusy_q || rdBusy_q)
        begin
            if (cnt_q == 9'h001)
            begin
                wrBusy_d = 1'b0;
                rdBusy_d = 1'b0;
                wrDone_d = wrBusy_q;
                rdDone_d = rdBusy_q;
                if (rdBusy_q)
                begin
                    rdData_d = mem[addr_q];
                end
            end
            else
            begin
                cnt_d = cnt_q - 9'h001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrBusy_q <= 1'b0;
            rdBusy_q <= 1'b0;
            cnt_q <= 9'h000;
            lfsr_q <= `NVB_RST_LFSR;
            addr_q <= `NVB_RST_ADDR;
            wdata_q <= `NVB_RST_BYTE;
            rdData_q <= `NVB_RST_BYTE;
            wrDone_q <= 1'b0;
            rdDone_q <= 1'b0;
        end
        else
        begin
            wrBusy_q <= wrBusy_d;
            rdBusy_q <= rdBusy_d;
            cnt_q <= cnt_d;
            lfsr_q <= lfsr_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdData_q <= rdData_d;
            wrDone_q <= wrDone_d;
            rdDone_q <= rdDone_d;
        end
    end

    // the cells hold no reset: contents survive a reset like real storage
    always_ff @(posedge sys_clk)
    begin
        if (wrBusy_q && cnt_q == 9'h001)
        begin
            mem[addr_q] <= wdata_q;
        end
    end

    assign rdData = rdData_q;
    assign wrDone = wrDone_q;
    assign rdDone = rdDone_q;

endmodule
`default_nettype wire

/* File: test/nvb_cpu_model.sv */
// Purpose: cpu-side model driving the register port of the nv byte block
// Assumes: one access per wr or rd call; strobes one cycle wide, set 1 ns after an edge
// Notes: the bench calls the tasks through the instance
`timescale 1ns/1ps
`default_nettype none
`include "nvb_defines.svh"

module nvb_cpu_model (
    input wire logic sys_clk, // system clock
    output logic [7:0] regAddr, // access address
    output logic regWr, // write strobe
    output logic regRd, // read strobe
    output logic [7:0] regWdata, // write data
    input wire logic [7:0] regRdata // read data
);
    initial
    begin
        regAddr = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        regWdata = 8'hff;
    end

    // data is inverted once released so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regWdata = d;
        regWr = 1'b1;
        @(posedge sys_clk);
        #1;
        regWr = 1'b0;
        regWdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regRd = 1'b1;
        @(posedge sys_clk);
        #1;
        regRd = 1'b0;
        @(posedge sys_clk);
        #1;
        d = regRdata;
    endtask

    // go bits are only ever set one at a time, after their arm bit
    task automatic store_byte(input logic [7:0] a, input logic [7:0] d, input logic ie);
        wr(`NVB_OFF_IRQ, ie ? 8'h02 : 8'h00);
        wr(`NVB_OFF_ADDR, a);
        wr(`NVB_OFF_DATA, d);
        wr(`NVB_OFF_BANK, 8'h01);
        wr(`NVB_OFF_IND_PTR, `NVB_OFF_CTRL);
        wr(`NVB_OFF_IND_PORT, 8'h08);
        wr(`NVB_OFF_IND_PORT, 8'h0c);
        wr(`NVB_OFF_IRQ, ie ? 8'h03 : 8'h01);
    endtask

    // polls fetch_go before taking the byte
    task automatic fetch_byte(input logic [7:0] a, output logic [7:0] d, output int polls);
        wr(`NVB_OFF_BANK, 8'h01);
        wr(`NVB_OFF_IND_PTR, `NVB_OFF_CTRL);
        wr(`NVB_OFF_ADDR, a);
        wr(`NVB_OFF_IND_PORT, 8'h02);
        wr(`NVB_OFF_IND_PORT, 8'h03);
        polls = 0;
        d = 8'h01;
        while (d[0] !== 1'b0 && polls < 20)
        begin
            rd(`NVB_OFF_IND_PORT, d);
            polls++;
        end
        rd(`NVB_OFF_DATA, d);
    endtask
endmodule
`default_nettype wire

/* File: test/eeprom_byte_access_ctrl_tb_top.sv */
// Purpose: self-checking bench for the nv byte access controller
// Assumes: 125 MHz clock, reset held 12 cycles
// Notes: array contents are only compared after being written
`timescale 1ns/1ps
`default_nettype none
`include "nvb_defines.svh"

module eeprom_byte_access_ctrl_tb_top;
    logic sysClk;
    logic rstN;
    logic stackFull;
    logic [7:0] regAddr;
    logic regWr;
    logic regRd;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic irqCall;
    logic nvBusy;
    logic [7:0] v;
    int n;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int irqCnt = 0;

    nvb_ctrl nvb_ctrl_inst (.sys_clk(sysClk), .rst_n(rstN), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWdata(regWdata), .stackFull(stackFull), .regRdata(regRdata),
        .irqCall(irqCall), .nvBusy(nvBusy));
    nvb_cpu_model nvb_cpu_model_inst (.sys_clk(sysClk), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata));

    initial
    begin
        sysClk = 1'b0;
        forever #4 sysClk = ~sysClk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (err_total == 0 && tests_run > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chkRange(input int got, input int lo, input int hi, input string what);
        tests_run++;
        if (got < lo || got > hi)
        begin
            err_total++;
            $display("wrong value at %0t ns: %s count %0d outside %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    // no further access until the running cycle is over
    task automatic waitIdle(output int cnt);
        cnt = 0;
        while (nvBusy !== 1'b0 && cnt < 400)
        begin
            @(posedge sysClk);
            #1;
            cnt++;
        end
        // a cycle that never ends must not pass silently
        if (cnt >= 400)
        begin
            err_total++;
            $display("wrong value at %0t ns: busy never dropped", $time);
        end
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        nvb_cpu_model_inst.rd(a, d);
        chk8(d, exp, what);
    endtask

    always @(posedge sysClk)
    begin
        cycles++;
        if (irqCall === 1'b1)
        begin
            irqCnt++;
        end
        if (cycles == 6000)
        begin
            err_total++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstN = 1'b0;
        stackFull = 1'b0;
        repeat (12) @(posedge sysClk);
        #1;
        rstN = 1'b1;
        rdChk(`NVB_OFF_ADDR, 8'h00, "address after reset");
        rdChk(`NVB_OFF_DATA, 8'h00, "data after reset");
        rdChk(`NVB_OFF_BANK, 8'h00, "bank after reset");
        rdChk(`NVB_OFF_IRQ, 8'h00, "irq reg after reset");
        // direct 40h is bank 0 space and must not reach control
        nvb_cpu_model_inst.wr(8'h40, 8'h0a);
        nvb_cpu_model_inst.wr(`NVB_OFF_BANK, 8'hff);
        rdChk(`NVB_OFF_BANK, 8'h01, "bank upper bits");
        nvb_cpu_model_inst.wr(`NVB_OFF_IND_PTR, `NVB_OFF_CTRL);
        rdChk(`NVB_OFF_IND_PORT, 8'h00, "control after direct 40h");
        // go bits without arm are ignored
        nvb_cpu_model_inst.wr(`NVB_OFF_IND_PORT, 8'h04);
        rdChk(`NVB_OFF_IND_PORT, 8'h00, "store_go unarmed");
        chk8({7'h00, nvBusy}, 8'h00, "busy unarmed store");
        nvb_cpu_model_inst.wr(`NVB_OFF_IND_PORT, 8'h01);
        rdChk(`NVB_OFF_IND_PORT, 8'h00, "fetch_go unarmed");
        rdChk(`NVB_OFF_DATA, 8'h00, "data after unarmed fetch");
        // full write at the top address
        nvb_cpu_model_inst.store_byte(8'h1f, 8'ha5, 1'b0);
        chk8({7'h00, nvBusy}, 8'h01, "busy during write");
        waitIdle(n);
        chkRange(n, 240, 280, "write length");
        rdChk(`NVB_OFF_IND_PORT, 8'h08, "store_go after write");
        rdChk(`NVB_OFF_IRQ, 8'h05, "flag after write");
        nvb_cpu_model_inst.store_byte(8'h00, 8'h3c, 1'b0);
        waitIdle(n);
        nvb_cpu_model_inst.fetch_byte(8'h1f, v, n);
        chk8(v, 8'ha5, "byte at 1f");
        chkRange(n, 1, 4, "fetch polls");
        rdChk(`NVB_OFF_IND_PORT, 8'h02, "fetch_go after read");
        nvb_cpu_model_inst.fetch_byte(8'h00, v, n);
        chk8(v, 8'h3c, "byte at 00");
        chkRange(n, 1, 4, "fetch polls at 00");
        // store_go with store_arm cleared must leave the array alone
        nvb_cpu_model_inst.wr(`NVB_OFF_DATA, 8'h77);
        nvb_cpu_model_inst.wr(`NVB_OFF_IND_PORT, 8'h00);
        nvb_cpu_model_inst.wr(`NVB_OFF_IND_PORT, 8'h04);
        chk8({7'h00, nvBusy}, 8'h00, "busy disarmed store");
        nvb_cpu_model_inst.fetch_byte(8'h00, v, n);
        chk8(v, 8'h3c, "byte kept at 00");
        chkRange(n, 1, 4, "fetch polls after disarm");
        chkRange(irqCnt, 0, 0, "calls without enable");
        // interrupt held off by a full stack, then taken
        stackFull = 1'b1;
        nvb_cpu_model_inst.store_byte(8'h0a, 8'h5a, 1'b1);
        waitIdle(n);
        repeat (3) @(posedge sysClk);
        #1;
        chkRange(irqCnt, 0, 0, "call with full stack");
        rdChk(`NVB_OFF_IRQ, 8'h07, "flag pending");
        stackFull = 1'b0;
        repeat (4) @(posedge sysClk);
        #1;
        chkRange(irqCnt, 1, 1, "one call");
        rdChk(`NVB_OFF_IRQ, 8'h02, "service clears");
        nvb_cpu_model_inst.fetch_byte(8'h0a, v, n);
        chk8(v, 8'h5a, "byte at 0a");
        chkRange(n, 1, 4, "fetch polls at 0a");
        end_of_test();
    end
endmodule
`default_nettype wire
